/* design/touch_timing.sv */
// touch duration classing, sample sequencing and recalibration
`timescale 1ns/1ns
`default_nettype none
`include "touch_timing_cfg.svh"
// Notes on behaviour
// - hold threshold field, reset 0111b
// - short touch reported as ordinary touch
// - hold classing only on auto-repeat inputs
// - threshold is (code+1) times 35ms
// - samples per channel two to code
// - all samples per channel, ascending order
// - average samples, then update result
// - sample time 320us shifted by code
// - cycle period (code+1) times 35ms
// - sampling starts at each cycle start that has an input enabled
// - low power for rest of cycle
// - overrun lengthens cycle, samples kept
// - settings govern only in active state
// - request bit recalibrates that input
// - suppress presses, base invalid, 600ms
// - press during recalibration restarts it
// - store 10-bit calibration result
// - request bit self-clears on success
// - only enabled inputs sampled, fixed period
module touch_timing #(
    parameter int TICK_CYC    = `TICK_CYC,
    parameter int HOLD_STEP   = `HOLD_STEP_US,
    parameter int SAMPLE_BASE = `SAMPLE_BASE_US,
    parameter int CYCLE_STEP  = `CYCLE_STEP_US,
    parameter int RECAL_TIME  = `RECAL_US
) (
    input  wire logic                        I_CLK,
    input  wire logic                        I_RST,
    input  wire logic                        I_ACTIVE,
    input  wire logic                        I_WR_EN,
    input  wire logic [7:0]                  I_ADDR,
    input  wire logic [7:0]                  I_WR_DATA,
    output logic      [7:0]                  O_RD_DATA,
    input  wire logic [15:0]                 I_SAMPLE,
    input  wire logic [5:0]                  I_TOUCH,
    input  wire logic [9:0]                  I_CAL_VALUE,
    output logic                             O_SAMPLING,
    output logic                             O_LOW_POWER,
    output logic      [2:0]                  O_SAMPLE_CH,
    output touch_timing_pkg::result_t        O_RESULT,
    output logic                             O_RESULT_VALID,
    output logic      [5:0]                  O_RECAL_ACTIVE,
    output touch_timing_pkg::cal_bank_t      O_CAL_RESULT,
    output logic      [5:0]                  O_TOUCH_EVT,
    output logic      [5:0]                  O_HOLD
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    // ------------------------------------------------------------
    // microsecond tick
    // ------------------------------------------------------------
    logic [15:0] pre_ff;
    logic        tick;
    assign tick = (pre_ff == 16'(TICK_CYC - 1));
    // one divider feeds every timer so they all agree
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            pre_ff <= 16'h0000;
        end else begin
            pre_ff <= tick ? 16'h0000 : pre_ff + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [5:0] in_en_ff;
    logic [3:0] hold_thr_ff;
    logic [6:0] avg_ff;
    logic [5:0] recal_req_ff;
    logic [5:0] auto_rpt_ff;
    logic [5:0] rc_done_mask;
    logic [5:0] nxt_recal_req;
    logic       wr_recal;
    assign wr_recal = I_WR_EN && (I_ADDR == `ADDR_RECAL_REQ);
    // a write of one wins over a finishing recalibration
    assign nxt_recal_req = (recal_req_ff & ~rc_done_mask)
                         | (wr_recal ? I_WR_DATA[5:0] : 6'h00);
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            in_en_ff     <= `RST_INPUT_ENABLE;
            hold_thr_ff  <= `RST_HOLD_THR;
            avg_ff       <= `RST_AVG_SAMPLE;
            recal_req_ff <= `RST_RECAL_REQ;
            auto_rpt_ff  <= `RST_AUTO_REPEAT;
        end else begin
            recal_req_ff <= nxt_recal_req;
            if (I_WR_EN) begin
                if (I_ADDR == `ADDR_INPUT_ENABLE) begin
                    in_en_ff <= I_WR_DATA[5:0];
                end else if (I_ADDR == `ADDR_HOLD_THR) begin
                    hold_thr_ff <= I_WR_DATA[`HOLD_MSB:`HOLD_LSB];
                end else if (I_ADDR == `ADDR_AVG_SAMPLE) begin
                    avg_ff <= I_WR_DATA[6:0];
                end else if (I_ADDR == `ADDR_AUTO_REPEAT) begin
                    auto_rpt_ff <= I_WR_DATA[5:0];
                end
            end
        end
    end

    // read data one cycle after the address; unmapped reads zero
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_RD_DATA <= 8'h00;
        end else if (I_ADDR == `ADDR_INPUT_ENABLE) begin
            O_RD_DATA <= {2'h0, in_en_ff};
        end else if (I_ADDR == `ADDR_HOLD_THR) begin
            O_RD_DATA <= {4'h0, hold_thr_ff};
        end else if (I_ADDR == `ADDR_AVG_SAMPLE) begin
            O_RD_DATA <= {1'h0, avg_ff};
        end else if (I_ADDR == `ADDR_RECAL_REQ) begin
            O_RD_DATA <= {2'h0, recal_req_ff};
        end else if (I_ADDR == `ADDR_AUTO_REPEAT) begin
            O_RD_DATA <= {2'h0, auto_rpt_ff};
        end else begin
            O_RD_DATA <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // decoded durations in microseconds
    // ------------------------------------------------------------
    logic [2:0]  cnt_code;
    logic [7:0]  n_samples;
    logic [21:0] samp_us;
    logic [21:0] period_us;
    logic [21:0] thr_us;
    assign cnt_code  = avg_ff[`CNT_MSB:`CNT_LSB];
    assign n_samples = 8'h01 << cnt_code;
    assign samp_us   = 22'(SAMPLE_BASE) << avg_ff[`DUR_MSB:`DUR_LSB];
    assign period_us = 22'(CYCLE_STEP) * (22'(avg_ff[`CYC_MSB:`CYC_LSB]) + 22'h1);
    assign thr_us    = 22'(HOLD_STEP) * (22'(hold_thr_ff) + 22'h1);

    // lowest enabled channel at or above 'from'; 6 means none left
    function automatic logic [2:0] next_ch(input logic [5:0] en, input logic [3:0] from);
        logic [2:0] r;
        r = 3'h6;
        for (int k = 5; k >= 0; k--) begin
            if (en[k] && (4'(k) >= from)) begin
                r = 3'(k);
            end
        end
        return r;
    endfunction : next_ch

    // ------------------------------------------------------------
    // sampling sequencer
    // ------------------------------------------------------------
    touch_timing_pkg::seq_state_t state_ff;
    logic [21:0] cyc_us_ff;
    logic [21:0] smp_us_ff;
    logic [7:0]  smp_cnt_ff;
    logic [22:0] acc_ff;
    logic [2:0]  ch_ff;
    logic        cyc_start;
    logic        smp_end;
    logic        ch_end;
    logic [22:0] nxt_acc;
    logic [2:0]  nxt_ch;
    // no new cycle while sampling, so an overrun simply stretches it
    assign cyc_start = (state_ff == touch_timing_pkg::ST_LOW_PWR) && I_ACTIVE && tick
                     && (cyc_us_ff >= period_us - 22'h1);
    assign smp_end = (state_ff == touch_timing_pkg::ST_SAMPLE) && tick
                   && (smp_us_ff == samp_us - 22'h1);
    assign ch_end  = smp_end && (smp_cnt_ff == n_samples - 8'h01);
    assign nxt_acc = acc_ff + 23'(I_SAMPLE);
    assign nxt_ch  = next_ch(in_en_ff, 4'(ch_ff) + 4'h1);

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            state_ff   <= touch_timing_pkg::ST_LOW_PWR;
            cyc_us_ff  <= 22'h000000;
            smp_us_ff  <= 22'h000000;
            smp_cnt_ff <= 8'h00;
            acc_ff     <= 23'h000000;
            ch_ff      <= 3'h0;
        end else begin
            if (cyc_start) begin
                cyc_us_ff <= 22'h000000;
            end else if (tick && (cyc_us_ff != 22'h3FFFFF)) begin
                cyc_us_ff <= cyc_us_ff + 22'h000001;
            end
            case (state_ff)
                touch_timing_pkg::ST_LOW_PWR: begin
                    // with no input enabled the period still runs on
                    if (cyc_start && (next_ch(in_en_ff, 4'h0) != 3'h6)) begin
                        state_ff   <= touch_timing_pkg::ST_SAMPLE;
                        ch_ff      <= next_ch(in_en_ff, 4'h0);
                        smp_us_ff  <= 22'h000000;
                        smp_cnt_ff <= 8'h00;
                        acc_ff     <= 23'h000000;
                    end
                end
                touch_timing_pkg::ST_SAMPLE: begin
                    if (tick) begin
                        smp_us_ff <= smp_end ? 22'h000000 : smp_us_ff + 22'h000001;
                    end
                    if (ch_end) begin
                        smp_cnt_ff <= 8'h00;
                        acc_ff     <= 23'h000000;
                        if (nxt_ch == 3'h6) begin
                            state_ff <= touch_timing_pkg::ST_LOW_PWR;
                        end else begin
                            ch_ff <= nxt_ch;
                        end
                    end else if (smp_end) begin
                        smp_cnt_ff <= smp_cnt_ff + 8'h01;
                        acc_ff     <= nxt_acc;
                    end
                end
                default: begin
                    state_ff <= touch_timing_pkg::ST_LOW_PWR;
                end
            endcase
        end
    end

    // averaged result leaves only once a channel's samples are all in
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_RESULT       <= '0;
            O_RESULT_VALID <= 1'b0;
            O_SAMPLING     <= 1'b0;
            O_LOW_POWER    <= 1'b1;
            O_SAMPLE_CH    <= 3'h0;
        end else begin
            O_RESULT_VALID <= ch_end;
            if (ch_end) begin
                O_RESULT.ch    <= ch_ff;
                O_RESULT.value <= 16'(nxt_acc >> cnt_code);
            end
            O_SAMPLING  <= (state_ff == touch_timing_pkg::ST_SAMPLE);
            O_LOW_POWER <= (state_ff == touch_timing_pkg::ST_LOW_PWR);
            O_SAMPLE_CH <= ch_ff;
        end
    end

    sequence seq_last_sample;
        (state_ff == touch_timing_pkg::ST_SAMPLE) ##1 (state_ff == touch_timing_pkg::ST_LOW_PWR);
    endsequence
    sequence seq_ch_step;
        (state_ff == touch_timing_pkg::ST_SAMPLE) && O_SAMPLING && (O_SAMPLE_CH != ch_ff);
    endsequence
    low_power_entry_a: assert property (seq_last_sample |=> O_LOW_POWER && !O_SAMPLING)
        else $error("no low power after last sample");
    ascending_order_a: assert property (seq_ch_step |-> ch_ff > O_SAMPLE_CH)
        else $error("channel order not ascending");
    result_count_a: assert property (O_RESULT_VALID |-> $past(smp_cnt_ff) == n_samples - 8'h01)
        else $error("result before all samples");
    sample_time_a: assert property (O_SAMPLING |-> smp_us_ff < samp_us)
        else $error("sample window overran");
    cycle_start_a: assert property (cyc_start |-> cyc_us_ff + 22'h1 >= period_us)
        else $error("cycle started early");
    enabled_only_a: assert property (O_RESULT_VALID |-> in_en_ff[O_RESULT.ch] || $past(I_WR_EN, 1))
        else $error("disabled channel measured");

    // ------------------------------------------------------------
    // recalibration engine, one input at a time, lowest first
    // ------------------------------------------------------------
    logic        rc_busy_ff;
    logic [2:0]  rc_ch_ff;
    logic [19:0] rc_us_ff;
    logic        rc_done;
    assign rc_done = rc_busy_ff && tick && (rc_us_ff == 20'(RECAL_TIME - 1));
    assign rc_done_mask = rc_done ? (6'h01 << rc_ch_ff) : 6'h00;
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            rc_busy_ff     <= 1'b0;
            rc_ch_ff       <= 3'h0;
            rc_us_ff       <= 20'h00000;
            O_RECAL_ACTIVE <= 6'h00;
            O_CAL_RESULT   <= '0;
        end else begin
            if (!rc_busy_ff) begin
                if (recal_req_ff != 6'h00) begin
                    rc_busy_ff <= 1'b1;
                    rc_ch_ff   <= next_ch(recal_req_ff, 4'h0);
                    rc_us_ff   <= 20'h00000;
                end
            end else if (I_TOUCH[rc_ch_ff]) begin
                rc_us_ff <= 20'h00000;
            end else if (rc_done) begin
                rc_busy_ff             <= 1'b0;
                O_CAL_RESULT[rc_ch_ff] <= I_CAL_VALUE;
            end else if (tick) begin
                rc_us_ff <= rc_us_ff + 20'h00001;
            end
            // base count invalid and presses blocked while active
            O_RECAL_ACTIVE <= (rc_busy_ff && !rc_done) ? (6'h01 << rc_ch_ff) : 6'h00;
        end
    end

    recal_clear_a: assert property (rc_done && !wr_recal |=> !recal_req_ff[$past(rc_ch_ff)])
        else $error("request bit not cleared");
    recal_press_a: assert property (rc_busy_ff && I_TOUCH[rc_ch_ff] |=> rc_us_ff == 20'h0)
        else $error("press did not restart recal");

    // ------------------------------------------------------------
    // touch duration classing, one slice per input
    // ------------------------------------------------------------
    logic [5:0]  touch_ok;
    logic [5:0]  touch_q_ff;
    logic [21:0] held_us_ff [6];
    assign touch_ok = I_TOUCH & ~O_RECAL_ACTIVE;
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            touch_q_ff <= 6'h00;
        end else begin
            touch_q_ff <= touch_ok;
        end
    end
    for (genvar g = 0; g < 6; g++) begin : g_ch
        always_ff @(posedge I_CLK or posedge I_RST) begin
            if (I_RST) begin
                held_us_ff[g]  <= 22'h000000;
                O_HOLD[g]      <= 1'b0;
                O_TOUCH_EVT[g] <= 1'b0;
            end else begin
                if (!touch_ok[g]) begin
                    held_us_ff[g] <= 22'h000000;
                end else if (tick && (held_us_ff[g] != 22'h3FFFFF)) begin
                    held_us_ff[g] <= held_us_ff[g] + 22'h000001;
                end
                // strictly longer than the threshold means press and hold
                O_HOLD[g] <= touch_ok[g] && auto_rpt_ff[g] && (held_us_ff[g] > thr_us);
                if (auto_rpt_ff[g]) begin
                    // released at or under threshold: ordinary touch
                    O_TOUCH_EVT[g] <= touch_q_ff[g] && !touch_ok[g] && !O_HOLD[g];
                end else begin
                    O_TOUCH_EVT[g] <= touch_ok[g] && !touch_q_ff[g];
                end
            end
        end
    end

    hold_auto_only_a: assert property ((O_HOLD & ~$past(auto_rpt_ff)) == 6'h00)
        else $error("hold on non auto-repeat input");
    hold_threshold_a: assert property ($rose(O_HOLD[0]) |-> $past(held_us_ff[0]) > $past(thr_us))
        else $error("hold before threshold");
    short_touch_a: assert property ((O_TOUCH_EVT & $past(O_HOLD) & $past(auto_rpt_ff)) == 6'h00)
        else $error("touch event after hold");
endmodule : touch_timing
`default_nettype wire

/* design/touch_timing_cfg.svh */
// register map, reset values, field positions and timing counts
`ifndef TOUCH_TIMING_CFG_SVH
`define TOUCH_TIMING_CFG_SVH
// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define ADDR_INPUT_ENABLE 8'h21
`define ADDR_HOLD_THR     8'h23
`define ADDR_AVG_SAMPLE   8'h24
`define ADDR_RECAL_REQ    8'h26
`define ADDR_AUTO_REPEAT  8'h28
`define RST_INPUT_ENABLE  6'h3F
`define RST_HOLD_THR      4'h7
`define RST_AVG_SAMPLE    7'h39
`define RST_RECAL_REQ     6'h00
`define RST_AUTO_REPEAT   6'h3F
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define HOLD_MSB 3
`define HOLD_LSB 0
`define CNT_MSB  6
`define CNT_LSB  4
`define DUR_MSB  3
`define DUR_LSB  2
`define CYC_MSB  1
`define CYC_LSB  0
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS  20
`define TICK_NS        1000
`define TICK_CYC       (`TICK_NS / `CLK_PERIOD_NS)
`define HOLD_STEP_US   35000
`define SAMPLE_BASE_US 320
`define CYCLE_STEP_US  35000
`define RECAL_US       600000
`endif

/* design/touch_timing_pkg.sv */
// types shared by the touch timing and recalibration block
package touch_timing_pkg;
    // sequencer: low-power wait or sampling a channel
    typedef enum logic [0:0] {
        ST_LOW_PWR = 1'b0,
        ST_SAMPLE  = 1'b1
    } seq_state_t;
    // one averaged channel measurement
    typedef struct packed {
        logic [2:0]  ch;
        logic [15:0] value;
    } result_t;
    // per-channel 10-bit calibration values
    typedef logic [5:0][9:0] cal_bank_t;
endpackage : touch_timing_pkg

/* verif/front_end_model.sv */
// front-end model: sample source, touch pads and calibration word
`timescale 1ns/1ns
`default_nettype none
module front_end_model (
    input  wire logic        i_clk,
    input  wire logic        i_sampling,
    input  wire logic [2:0]  i_ch,
    input  wire logic [15:0] i_base,
    input  wire logic [5:0]  i_press,
    input  wire logic [9:0]  i_cal,
    output logic      [15:0] o_sample,
    output logic      [5:0]  o_touch,
    output logic      [9:0]  o_cal_value
);
    logic [15:0] last_ff = 16'h0000;
    // remember the last measured word so an idle line can show its inverse
    always @(posedge i_clk) begin
        if (i_sampling) begin
            last_ff <= o_sample;
        end
    end
    // per-channel level while measuring; stale captures cannot match by luck
    assign o_sample    = i_sampling ? (i_base ^ {13'h0000, i_ch}) : ~last_ff;
    assign o_touch     = i_press;
    assign o_cal_value = i_cal;
endmodule : front_end_model
`default_nettype wire

/* verif/tb.sv */
// self-checking bench for the touch timing and recalibration block
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int TC = 2;
    localparam int HS = 35;
    localparam int SB = 4;
    localparam int CS = 200;
    logic        clk, rst, active, wr_en, sampling, low_power, rvalid;
    logic [7:0]  addr, wdata, rd_data;
    logic [15:0] sample, base;
    logic [5:0]  touch, press, recal_act, evt, hold;
    logic [9:0]  cal_v, calw;
    logic [2:0]  sch;
    logic        prev;
    touch_timing_pkg::result_t   result;
    touch_timing_pkg::cal_bank_t cal_res;
    touch_timing_pkg::result_t   q[$];
    int fails, tests_run, evt0, evt1, rises, seed, n, e, t, thr;
    logic [7:0] ra[6] = '{8'h21, 8'h23, 8'h24, 8'h26, 8'h28, 8'h25};
    logic [7:0] rv[6] = '{8'h3F, 8'h07, 8'h39, 8'h00, 8'h3F, 8'h00};
    logic [7:0] hc[3] = '{8'h00, 8'h07, 8'h0F};
    touch_timing #(.TICK_CYC(TC), .HOLD_STEP(HS), .SAMPLE_BASE(SB), .CYCLE_STEP(CS),
        .RECAL_TIME(50)) touch_timing_inst (.I_CLK(clk), .I_RST(rst), .I_ACTIVE(active),
        .I_WR_EN(wr_en), .I_ADDR(addr), .I_WR_DATA(wdata), .O_RD_DATA(rd_data),
        .I_SAMPLE(sample), .I_TOUCH(touch), .I_CAL_VALUE(cal_v), .O_SAMPLING(sampling),
        .O_LOW_POWER(low_power), .O_SAMPLE_CH(sch), .O_RESULT(result),
        .O_RESULT_VALID(rvalid), .O_RECAL_ACTIVE(recal_act), .O_CAL_RESULT(cal_res),
        .O_TOUCH_EVT(evt), .O_HOLD(hold));
    front_end_model front_end_model_inst (.i_clk(clk), .i_sampling(sampling), .i_ch(sch),
        .i_base(base), .i_press(press), .i_cal(calw), .o_sample(sample), .o_touch(touch),
        .o_cal_value(cal_v));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a; wdata = d; wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask : wr
    // read data is registered, so it is taken one edge after the address
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        check(rd_data, exp);
    endtask : rchk
    // bounded wait for a sequencer level; the time is in clock periods
    task automatic ws(input logic lv, output int tm);
        int k;
        k = 0;
        while (sampling !== lv && k < 20000) begin
            @(posedge clk);
            k++;
        end
        tm = int'($time / 20);
        if (k >= 20000) check(0, 1);
    endtask : ws
    task automatic we(input logic lv, output int tm);
        ws(!lv, tm);
        ws(lv, tm);
    endtask : we
    task automatic wcal(input int i, input logic [9:0] v, output int k);
        k = 0;
        while (cal_res[i] !== v && k < 1000) begin
            @(posedge clk);
            k++;
        end
    endtask : wcal
    // one skipped cycle lets new settings land before a cycle is measured
    task automatic meas(input int ac, input int dc, input int cc, input logic [5:0] en);
        int t0, t1, t2, w, p, m;
        // settings change only while the sequencer rests, never mid-window
        @(negedge clk);
        active = 1'b0;
        ws(1'b0, t0);
        wr(8'h21, {2'b00, en});
        wr(8'h24, 8'(ac * 16 + dc * 4 + cc));
        active = 1'b1;
        we(1'b1, t0);
        ws(1'b0, t1);
        @(negedge clk);
        base = 16'($random(seed));
        m = 0;
        for (int c = 0; c < 6; c++) begin
            if (en[c]) begin
                q.push_back(touch_timing_pkg::result_t'({3'(c), base ^ 16'(c)}));
                m++;
            end
        end
        we(1'b1, t0);
        check(low_power, 1'b0);
        ws(1'b0, t1);
        check(low_power, 1'b1);
        we(1'b1, t2);
        w = m * (1 << ac) * (SB << dc) * TC;
        p = (cc + 1) * CS * TC;
        check(t1 - t0 >= w - 4 && t1 - t0 <= w + 4, 1);
        if (w < p) check(t2 - t0 >= p - 2 && t2 - t0 <= p + 2, 1);
        else check(t2 - t0 > p && t2 - t0 <= w + 10, 1);
        check(q.size(), 0);
    endtask : meas
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------------------------------
    // clock, watchdog, output monitor
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // the tests take about 40k cycles; the limit leaves some margin
    initial begin
        #1900000;
        fails++;
        tally_and_finish();
    end
    // result notes are taken in order, so channel order shows in the ch field
    always @(posedge clk) begin
        if (evt[0] === 1'b1) evt0++;
        if (evt[1] === 1'b1) evt1++;
        if (sampling === 1'b1 && prev !== 1'b1) rises++;
        prev = sampling;
        if (rvalid === 1'b1 && q.size() > 0) check(result, q.pop_front());
    end
    // main sequence
    initial begin
        seed = 32'h02fe;
        rst = 1'b1; active = 1'b1; wr_en = 1'b0; addr = 8'h00; wdata = 8'h00;
        base = 16'h0000; press = 6'h00; calw = 10'h000; prev = 1'b0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        foreach (ra[i]) rchk(ra[i], rv[i]);
        wr(8'h23, 8'hFA);
        rchk(8'h23, 8'h0A);
        wr(8'h24, 8'hFF);
        rchk(8'h24, 8'h7F);
        wr(8'h25, 8'hFF);
        rchk(8'h25, 8'h00);
        $display("test registers done");
        for (int k = 0; k < 8; k++) meas(k, (k + 2) % 4, k % 4, (k == 3) ? 6'h2D : 6'h01);
        $display("test sampling done");
        wr(8'h28, 8'h3E);
        calw = 10'($random(seed)) | 10'h001;
        wr(8'h26, 8'h05);
        rchk(8'h26, 8'h05);
        repeat (2) @(negedge clk);
        check(recal_act, 6'h01);
        repeat (60) @(negedge clk);
        press = 6'h01;
        e = evt0;
        repeat (120) @(negedge clk);
        check(recal_act, 6'h01);
        check(evt0, e);
        press = 6'h00;
        wcal(0, calw, n);
        check(n >= 96 && n <= 106, 1);
        @(negedge clk);
        calw = calw ^ 10'h2AA;
        rchk(8'h26, 8'h04);
        wcal(2, calw, n);
        check(n <= 110, 1);
        rchk(8'h26, 8'h00);
        check(cal_res[1], 10'h000);
        $display("test recalibration done");
        foreach (hc[i]) begin
            wr(8'h23, hc[i]);
            thr = (hc[i] + 1) * HS * TC;
            @(negedge clk);
            press = 6'h02;
            n = 0;
            while (hold[1] !== 1'b1 && n < 3000) begin
                @(posedge clk);
                n++;
            end
            check(n >= thr && n <= thr + 8, 1);
            e = evt1;
            @(negedge clk);
            press = 6'h00;
            repeat (4) @(negedge clk);
            check(hold[1], 1'b0);
            check(evt1, e);
            press = 6'h02;
            repeat (thr - 6) @(negedge clk);
            press = 6'h00;
            repeat (4) @(negedge clk);
            check(evt1, e + 1);
            e = evt0;
            press = 6'h01;
            repeat (thr + 20) @(negedge clk);
            check(evt0, e + 1);
            check(hold[0], 1'b0);
            press = 6'h00;
        end
        $display("test hold done");
        active = 1'b0;
        ws(1'b0, t);
        wr(8'h24, 8'h10);
        repeat (5) @(negedge clk);
        e = rises;
        repeat (2000) @(negedge clk);
        check(rises, e);
        active = 1'b1;
        we(1'b1, t);
        $display("test active state done");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
